// *** pch_defines.svh ***
// Constants for the parameter command handler
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH
`define PCH_FRAME_BYTES     4'd9
`define PCH_OP_SET_AXIS     8'h05
`define PCH_OP_GET_AXIS     8'h06
`define PCH_OP_STORE_AXIS   8'h07
`define PCH_OP_RESTORE_AXIS 8'h08
`define PCH_OP_SET_GLOBAL   8'h09
`define PCH_OP_GET_GLOBAL   8'h0a
`define PCH_OP_STORE_GLOBAL 8'h0b
`define PCH_BANK_MODULE     8'h00
`define PCH_BANK_USER       8'h02
`define PCH_BANK_IRQ        8'h03
`define PCH_ST_OK           8'h64
`define PCH_ST_BAD_CMD      8'h02
`define PCH_ST_BAD_TYPE     8'h03
`define PCH_ST_BAD_VALUE    8'h04
`endif

// *** pch_pkg.sv ***
// Types for the parameter command handler
package pch_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  ptype;
    logic [7:0]  bank;
    logic [31:0] value;
  } pch_frame_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } pch_reply_t;

  typedef enum logic [2:0] {
    PCH_BOOT  = 3'b000,
    PCH_IDLE  = 3'b001,
    PCH_EXEC  = 3'b011,
    PCH_NVWR  = 3'b010,
    PCH_NVRD  = 3'b110,
    PCH_REPLY = 3'b111
  } pch_state_t;
endpackage

// *** pch_frame_rx.sv ***
// Nine-byte frame assembler with checksum check
`timescale 1ns/1ns
`include "pch_defines.svh"
module pch_frame_rx
  import pch_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] rx_byte_i,
  input  wire logic       rx_valid_i,
  input  wire logic       busy_i,
  output pch_frame_t      frame_o,
  output logic            frame_valid_o
);
  logic [7:0]  buf_r [0:7];
  logic [3:0]  cnt_r;
  logic [7:0]  sum_r;
  logic        fv_r;
  pch_frame_t  frame_r;
  wire         last_byte = rx_valid_i && (cnt_r == `PCH_FRAME_BYTES - 4'd1);
  wire         sum_ok    = (sum_r == rx_byte_i);

  // =========================================================
  // Byte collection; bytes arriving while busy are dropped
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'd0;
      sum_r <= 8'h00;
      fv_r  <= 1'b0;
    end else begin
      fv_r <= 1'b0;
      if (rx_valid_i && !busy_i) begin
        if (last_byte) begin
          cnt_r <= 4'd0;
          sum_r <= 8'h00;
          fv_r  <= sum_ok; // Bad sum discards the frame [R02]
        end else begin
          buf_r[cnt_r[2:0]] <= rx_byte_i; // Field order [R01]
          cnt_r <= cnt_r + 4'd1;
          sum_r <= sum_r + rx_byte_i; // Modulo-256 sum [R02]
        end
      end
    end
  end

  // Frame capture, value most significant byte first
  always_ff @(posedge sys_clk_i) begin
    if (last_byte && !busy_i) begin
      frame_r <= {buf_r[0], buf_r[1], buf_r[2], buf_r[3],
                  buf_r[4], buf_r[5], buf_r[6], buf_r[7]}; // [R01]
    end
  end

  assign frame_o       = frame_r;
  assign frame_valid_o = fv_r;

  chk_sum_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R02]
    (last_byte && !busy_i && !sum_ok) |=> !frame_valid_o)
    else $error("frame with bad checksum accepted");
endmodule

// *** pch_param_handler.sv ***
// Parameter command handler: axis and global parameter access with persistence
// =========================================================
// Functional notes
// R01 - A frame is address, instruction, type, motor or bank, four value bytes MSB first, checksum.
// R02 - The checksum is the modulo-256 sum of the first eight bytes and bad frames are dropped.
// R03 - Instruction 5 writes the value into the axis parameter chosen by the type field.
// R04 - The host places parameter number in type, axis in motor and the value in value bytes.
// R05 - Axis parameters set by instruction 5 live only in volatile storage until stored.
// R06 - Instruction 6 reads an axis parameter and in standalone mode loads the accumulator.
// R07 - In direct mode an axis read leaves the accumulator unchanged.
// R08 - A successful read replies status 100 with the value read.
// R09 - Instruction 7 copies the selected axis parameter to non-volatile memory.
// R10 - Instruction 8 reloads the selected axis parameter from its non-volatile copy.
// R11 - After power-up every axis parameter is loaded from non-volatile memory.
// R12 - Instruction 9 writes a global parameter in bank 0, 2 or 3.
// R13 - A bank 0 write is persisted to non-volatile memory automatically.
// R14 - Instruction 10 copies a global parameter to the accumulator and replies with it.
// R15 - The global store copies the selected parameter, mainly bank 2, to non-volatile memory.
// R16 - The global store uses instruction 11 with bank 2 and a don't-care value.
// R17 - Successful set and store commands reply status 100.
`timescale 1ns/1ns
`include "pch_defines.svh"
module pch_param_handler
  import pch_pkg::*;
#(
  parameter int AXIS_PARAMS = 256,
  parameter int GLOB_PARAMS = 256
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  module_addr_i,
  input  wire logic        standalone_i,
  input  wire logic        nv_ready_i,
  input  wire logic [31:0] nv_rdata_i,
  input  wire logic        nv_rvalid_i,
  output logic             nv_wr_o,
  output logic             nv_rd_o,
  output logic [10:0]      nv_addr_o,
  output logic [31:0]      nv_wdata_o,
  output pch_reply_t       reply_o,
  output logic             reply_valid_o,
  output logic [31:0]      accu_o,
  output logic             boot_done_o
);
  // =========================================================
  // Storage: axis parameters in volatile RAM, globals per bank
  logic [31:0] axis_mem  [0:AXIS_PARAMS-1];
  logic [31:0] glob_mem  [0:4*GLOB_PARAMS-1]; // Bank 1 slot unused so bank bits index directly

  pch_state_t  state_r;
  pch_frame_t  frame;
  pch_frame_t  cmd_r;
  logic        frame_valid;
  logic [31:0] accu_r;
  logic [7:0]  boot_idx_r;
  logic        nv_is_read_r;
  logic        nv_wr_r;
  logic        nv_rd_r;
  logic [10:0] nv_addr_r;
  logic [31:0] nv_wdata_r;
  pch_reply_t  reply_r;
  logic        reply_valid_r;
  logic        pending_r;

  // Frame assembly; bytes are dropped while a command is in flight
  pch_frame_rx u_rx (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .rx_byte_i     (rx_byte_i),
    .rx_valid_i    (rx_valid_i),
    .busy_i        (state_r != PCH_IDLE),
    .frame_o       (frame),
    .frame_valid_o (frame_valid)
  );

  // =========================================================
  // Command decode
  wire for_me     = frame_valid && (frame.addr == module_addr_i);
  wire [1:0] bsel = cmd_r.bank[1:0];
  wire bank_ok    = (cmd_r.bank == `PCH_BANK_MODULE) || (cmd_r.bank == `PCH_BANK_USER) ||
                    (cmd_r.bank == `PCH_BANK_IRQ); // [R12]
  wire axis_ok    = (cmd_r.bank == 8'h00); // Single axis module
  wire [9:0] gidx = {bsel, cmd_r.ptype};
  wire [31:0] axis_rd = axis_mem[cmd_r.ptype];
  wire [31:0] glob_rd = glob_mem[gidx];
  wire is_axis_op = (cmd_r.instr >= `PCH_OP_SET_AXIS) && (cmd_r.instr <= `PCH_OP_RESTORE_AXIS);
  wire is_glob_op = (cmd_r.instr >= `PCH_OP_SET_GLOBAL) &&
                    (cmd_r.instr <= `PCH_OP_STORE_GLOBAL);
  wire sel_ok     = is_axis_op ? axis_ok : bank_ok;
  // Non-volatile map: axis at 0..255, globals above with bank in upper bits
  wire [10:0] nv_axis_addr = {3'b000, cmd_r.ptype};
  wire [10:0] nv_glob_addr = {1'b1, gidx};
  wire nv_free   = nv_ready_i && !nv_wr_r && !nv_rd_r;

  // =========================================================
  // Main sequencer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r       <= PCH_BOOT;
      boot_idx_r    <= 8'h00;
      pending_r     <= 1'b0;
      nv_is_read_r  <= 1'b0;
      nv_wr_r       <= 1'b0;
      nv_rd_r       <= 1'b0;
      nv_addr_r     <= 11'h000;
      nv_wdata_r    <= 32'h0000_0000;
      accu_r        <= 32'h0000_0000;
      reply_valid_r <= 1'b0;
      reply_r       <= '0;
      cmd_r         <= '0;
    end else begin
      nv_wr_r       <= 1'b0;
      nv_rd_r       <= 1'b0;
      reply_valid_r <= 1'b0;
      unique case (state_r)
        // Power-up load of every axis parameter, one read at a time
        PCH_BOOT: begin
          if (!pending_r && nv_free) begin
            nv_rd_r   <= 1'b1; // [R11]
            nv_addr_r <= {3'b000, boot_idx_r};
            pending_r <= 1'b1;
          end else if (pending_r && nv_rvalid_i) begin
            axis_mem[boot_idx_r] <= nv_rdata_i; // [R11]
            pending_r  <= 1'b0;
            boot_idx_r <= boot_idx_r + 8'h01;
            if (boot_idx_r == 8'(AXIS_PARAMS - 1)) begin
              state_r <= PCH_IDLE;
            end
          end
        end
        PCH_IDLE: begin
          if (for_me) begin
            cmd_r   <= frame;
            state_r <= PCH_EXEC;
          end
        end
        PCH_EXEC: begin
          reply_r.instr  <= cmd_r.instr;
          reply_r.status <= `PCH_ST_OK;
          reply_r.value  <= 32'h0000_0000;
          state_r        <= PCH_REPLY;
          if (!is_axis_op && !is_glob_op) begin
            reply_r.status <= `PCH_ST_BAD_CMD;
          end else if (!sel_ok) begin
            reply_r.status <= `PCH_ST_BAD_VALUE;
          end else begin
            unique case (cmd_r.instr)
              `PCH_OP_SET_AXIS: begin
                axis_mem[cmd_r.ptype] <= cmd_r.value; // RAM only, no NV write [R03] [R05]
              end
              `PCH_OP_GET_AXIS: begin
                reply_r.value <= axis_rd; // [R08]
                if (standalone_i) begin
                  accu_r <= axis_rd; // Direct mode skips this [R06] [R07]
                end
              end
              `PCH_OP_STORE_AXIS: begin
                nv_addr_r    <= nv_axis_addr; // [R09]
                nv_wdata_r   <= axis_rd;
                nv_is_read_r <= 1'b0;
                state_r      <= PCH_NVWR;
              end
              `PCH_OP_RESTORE_AXIS: begin
                nv_addr_r    <= nv_axis_addr; // [R10]
                nv_is_read_r <= 1'b1;
                state_r      <= PCH_NVWR;
              end
              `PCH_OP_SET_GLOBAL: begin
                glob_mem[gidx] <= cmd_r.value; // [R12]
                if (cmd_r.bank == `PCH_BANK_MODULE) begin
                  nv_addr_r    <= nv_glob_addr; // Auto persist [R13]
                  nv_wdata_r   <= cmd_r.value;
                  nv_is_read_r <= 1'b0;
                  state_r      <= PCH_NVWR;
                end
              end
              `PCH_OP_GET_GLOBAL: begin
                accu_r        <= glob_rd; // [R14]
                reply_r.value <= glob_rd; // [R08]
              end
              default: begin
                nv_addr_r    <= nv_glob_addr; // Store global [R15] [R16]
                nv_wdata_r   <= glob_rd;
                nv_is_read_r <= 1'b0;
                state_r      <= PCH_NVWR;
              end
            endcase
          end
        end
        // Issue one memory access once the memory is ready
        PCH_NVWR: begin
          if (nv_free) begin
            nv_wr_r   <= !nv_is_read_r;
            nv_rd_r   <= nv_is_read_r;
            state_r   <= nv_is_read_r ? PCH_NVRD : PCH_REPLY;
          end
        end
        PCH_NVRD: begin
          if (nv_rvalid_i) begin
            axis_mem[cmd_r.ptype] <= nv_rdata_i; // Overwrites RAM copy [R10]
            state_r <= PCH_REPLY;
          end
        end
        PCH_REPLY: begin
          reply_valid_r <= 1'b1; // Status 100 on success [R17]
          state_r       <= PCH_IDLE;
        end
        default: state_r <= PCH_IDLE;
      endcase
    end
  end

  // =========================================================
  // Outputs
  assign nv_wr_o       = nv_wr_r;
  assign nv_rd_o       = nv_rd_r;
  assign nv_addr_o     = nv_addr_r;
  assign nv_wdata_o    = nv_wdata_r;
  assign reply_o       = reply_r;
  assign reply_valid_o = reply_valid_r;
  assign accu_o        = accu_r;
  assign boot_done_o   = (state_r != PCH_BOOT);

  // =========================================================
  // Checks
  sequence set_axis_seen;
    state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_SET_AXIS && axis_ok;
  endsequence

  set_axis_nv_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R05]
    set_axis_seen |-> ##1 (!nv_wr_o [*2]))
    else $error("axis set wrote non-volatile memory");

  set_axis_ok_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R03]
    set_axis_seen |-> ##2 (reply_valid_o && reply_o.status == `PCH_ST_OK))
    else $error("axis set reply wrong");

  direct_accu_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R07]
    (state_r == PCH_EXEC && !standalone_i) |=> $stable(accu_o) || $past(cmd_r.instr) ==
      `PCH_OP_GET_GLOBAL)
    else $error("accumulator changed in direct mode");

  get_axis_val_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R06]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_GET_AXIS && axis_ok && standalone_i)
      |=> accu_o == reply_o.value)
    else $error("standalone read missed accumulator");

  get_glob_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R14]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_GET_GLOBAL && bank_ok)
      |=> accu_o == $past(glob_rd) ##1 (reply_valid_o && reply_o.status == `PCH_ST_OK))
    else $error("global read wrong");

  bank0_persist_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R13]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_SET_GLOBAL && cmd_r.bank == 8'h00)
      |=> state_r == PCH_NVWR)
    else $error("bank 0 write not persisted");

  store_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R09]
    (state_r == PCH_NVWR && nv_free && !nv_is_read_r) |=> nv_wr_o ##1 reply_valid_o)
    else $error("store did not write memory");

  restore_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R10]
    (state_r == PCH_NVWR && nv_free && nv_is_read_r) |=> nv_rd_o && !nv_wr_o)
    else $error("restore did not read memory");

  boot_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R11]
    (state_r == PCH_BOOT) |-> !reply_valid_o && !nv_wr_o)
    else $error("activity before boot load done");

  // Restore steps: read issued, answer written back, then the reply
  sequence restore_issue;
    state_r == PCH_NVWR && nv_free && nv_is_read_r;
  endsequence

  sequence restore_answer;
    state_r == PCH_NVRD && nv_rvalid_i;
  endsequence

  restore_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R10]
    restore_issue |=> nv_addr_o == {3'b000, cmd_r.ptype})
    else $error("restore read at wrong address");

  restore_land_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R10]
    restore_answer |=> axis_mem[cmd_r.ptype] == $past(nv_rdata_i) ##1 reply_valid_o)
    else $error("restored value not written back");

  store_axis_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R09]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_STORE_AXIS && axis_ok)
      |=> nv_wdata_o == $past(axis_rd) && nv_addr_o == {3'b000, cmd_r.ptype})
    else $error("axis store carries wrong word");

  store_glob_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R15]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_STORE_GLOBAL && bank_ok)
      |=> nv_wdata_o == $past(glob_rd) && nv_addr_o == {1'b1, cmd_r.bank[1:0], cmd_r.ptype})
    else $error("global store carries wrong word");

  set_glob_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R12]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_SET_GLOBAL && bank_ok)
      |=> glob_mem[{cmd_r.bank[1:0], cmd_r.ptype}] == cmd_r.value)
    else $error("global write did not land");

  bad_bank_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R12]
    (state_r == PCH_EXEC && cmd_r.instr == `PCH_OP_SET_GLOBAL && !bank_ok)
      |=> reply_o.status == `PCH_ST_BAD_VALUE && state_r == PCH_REPLY)
    else $error("bad bank not refused");

  reply_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R17]
    reply_valid_o |=> !reply_valid_o)
    else $error("reply strobe longer than one cycle");

  boot_addr_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [R11]
    (state_r == PCH_BOOT && nv_rd_o) |-> nv_addr_o[10:8] == 3'b000)
    else $error("boot load outside axis area");
endmodule

// *** pch_nv_model.sv ***
// Non-volatile memory model facing the parameter command handler
`timescale 1ns/1ns
module pch_nv_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        stall_i,
  input  wire logic        nv_wr_i,
  input  wire logic        nv_rd_i,
  input  wire logic [10:0] nv_addr_i,
  input  wire logic [31:0] nv_wdata_i,
  output logic             nv_ready_o,
  output logic [31:0]      nv_rdata_o,
  output logic             nv_rvalid_o
);
  logic [31:0] mem [0:2047];
  logic [1:0]  dly_r;
  logic [10:0] ra_r;
  // ==========================================================
  // Storage: preset pattern so each word is distinct
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 32'h5a00_0000 | i;
    end
  end
  // Slow mode holds off requests
  assign nv_ready_o = ~stall_i;
  // Writes land at once; reads answer three cycles after the request
  always_ff @(posedge sys_clk_i) begin
    if (nv_wr_i) begin
      mem[nv_addr_i] <= nv_wdata_i;
    end
    if (rst_i) begin
      dly_r <= 2'h0;
    end else if (nv_rd_i) begin
      ra_r  <= nv_addr_i;
      dly_r <= 2'h2;
    end else if (dly_r != 2'h0) begin
      dly_r <= dly_r - 2'h1;
    end
    nv_rvalid_o <= !rst_i && (dly_r == 2'h1);
    // Data bus flips outside the answer so stale data never looks valid
    nv_rdata_o <= (dly_r == 2'h1) ? mem[ra_r] : ~nv_rdata_o;
  end
endmodule

// *** pch_param_handler_tb_top.sv ***
// Self-checking testbench of the parameter command handler
`timescale 1ns/1ns
`include "pch_defines.svh"
module pch_param_handler_tb_top;
  import pch_pkg::*;
  logic sys_clk_i, rst_i, rx_valid_i, standalone_i, stall, nv_ready_i, nv_rvalid_i;
  logic nv_wr_o, nv_rd_o, reply_valid_o, boot_done_o;
  logic [7:0]  rx_byte_i, module_addr_i;
  logic [10:0] nv_addr_o;
  logic [31:0] nv_rdata_i, nv_wdata_o, accu_o, rv;
  pch_reply_t  reply_o;
  int num_errors, checks_done, cycles;
  pch_param_handler u_pch_param_handler (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .rx_byte_i(rx_byte_i), .rx_valid_i(rx_valid_i), .module_addr_i(module_addr_i),
    .standalone_i(standalone_i), .nv_ready_i(nv_ready_i), .nv_rdata_i(nv_rdata_i),
    .nv_rvalid_i(nv_rvalid_i), .nv_wr_o(nv_wr_o), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o),
    .nv_wdata_o(nv_wdata_o), .reply_o(reply_o), .reply_valid_o(reply_valid_o),
    .accu_o(accu_o), .boot_done_o(boot_done_o));
  pch_nv_model u_pch_nv_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
    .nv_wr_i(nv_wr_o), .nv_rd_i(nv_rd_o), .nv_addr_i(nv_addr_o), .nv_wdata_i(nv_wdata_o),
    .nv_ready_o(nv_ready_i), .nv_rdata_o(nv_rdata_i), .nv_rvalid_o(nv_rvalid_i));
  // ==========================================================
  // Clock and hang guard; boot alone takes about 1280 cycles
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One frame, MSB-first value, checksum optionally spoiled; waits for a reply
  task automatic send(input logic [7:0] a, ins, ty, bk, input logic [31:0] v,
                      input logic [7:0] spoil, output logic got);
    logic [7:0] b [0:8];
    logic [7:0] s;
    b = '{a, ins, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + b[i];
    b[8] = s + spoil;
    for (int i = 0; i < 9; i++) begin
      rx_byte_i  = b[i];
      rx_valid_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
    end
    rx_valid_i = 1'b0;
    got = 1'b0;
    for (int n = 0; n < 300 && !got; n++) begin
      @(posedge sys_clk_i);
      #1;
      got = (reply_valid_o === 1'b1);
    end
  endtask
  // Accepted command: returns the reply value and checks the status
  task automatic cmd(input logic [7:0] ins, ty, bk, input logic [31:0] v,
                     input logic [7:0] st);
    logic got;
    send(8'h01, ins, ty, bk, v, 8'h00, got);
    chk({31'h0, got}, 32'h1, "reply present");
    chk({24'h0, reply_o.status}, {24'h0, st}, "status");
    chk({24'h0, reply_o.instr}, {24'h0, ins}, "reply instruction");
    rv = reply_o.value;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_boot();
    for (int n = 0; n < 5000 && boot_done_o !== 1'b1; n++) @(posedge sys_clk_i);
    #1;
    cmd(`PCH_OP_GET_AXIS, 8'h04, 8'h00, 32'h0, `PCH_ST_OK);
    chk(rv, 32'h5a00_0004, "boot loaded axis param");
  endtask
  task automatic t_axis();
    cmd(`PCH_OP_SET_AXIS, 8'h04, 8'h00, 32'h0000_03e8, `PCH_ST_OK);
    cmd(`PCH_OP_GET_AXIS, 8'h04, 8'h00, 32'h0, `PCH_ST_OK);
    chk(rv, 32'h0000_03e8, "axis readback");
    chk(u_pch_nv_model.mem[4], 32'h5a00_0004, "set kept volatile");
    chk(accu_o, 32'h0, "direct read leaves accu");
    cmd(`PCH_OP_STORE_AXIS, 8'h04, 8'h00, 32'hffff_ffff, `PCH_ST_OK);
    chk(u_pch_nv_model.mem[4], 32'h0000_03e8, "axis stored");
    cmd(`PCH_OP_SET_AXIS, 8'h04, 8'h00, 32'h0000_0007, `PCH_ST_OK);
    stall = 1'b1; // Restore against a slow memory
    fork
      cmd(`PCH_OP_RESTORE_AXIS, 8'h04, 8'h00, 32'h1234_5678, `PCH_ST_OK);
      begin
        repeat (30) @(posedge sys_clk_i);
        #1 stall = 1'b0;
      end
    join
    cmd(`PCH_OP_GET_AXIS, 8'h04, 8'h00, 32'h0, `PCH_ST_OK);
    chk(rv, 32'h0000_03e8, "restored value");
    standalone_i = 1'b1;
    cmd(`PCH_OP_GET_AXIS, 8'h04, 8'h00, 32'h0, `PCH_ST_OK);
    chk(accu_o, 32'h0000_03e8, "standalone read loads accu");
    standalone_i = 1'b0;
  endtask
  task automatic t_global();
    cmd(`PCH_OP_SET_GLOBAL, 8'h2a, `PCH_BANK_USER, 32'hcafe_0042, `PCH_ST_OK);
    cmd(`PCH_OP_SET_GLOBAL, 8'h05, `PCH_BANK_IRQ, 32'h0000_0033, `PCH_ST_OK);
    cmd(`PCH_OP_SET_GLOBAL, 8'h42, `PCH_BANK_MODULE, 32'h0000_0003, `PCH_ST_OK);
    chk(u_pch_nv_model.mem[11'h442], 32'h0000_0003, "bank 0 persisted");
    cmd(`PCH_OP_GET_GLOBAL, 8'h2a, `PCH_BANK_USER, 32'hffff_ffff, `PCH_ST_OK);
    chk(rv, 32'hcafe_0042, "global readback");
    chk(accu_o, 32'hcafe_0042, "global read loads accu");
    cmd(`PCH_OP_GET_GLOBAL, 8'h05, `PCH_BANK_IRQ, 32'h0, `PCH_ST_OK);
    chk(rv, 32'h0000_0033, "bank 3 readback");
    chk(u_pch_nv_model.mem[11'h62a], 32'h5a00_062a, "user var not yet stored");
    cmd(`PCH_OP_STORE_GLOBAL, 8'h2a, `PCH_BANK_USER, 32'h0, `PCH_ST_OK);
    chk(u_pch_nv_model.mem[11'h62a], 32'hcafe_0042, "user var stored");
  endtask
  task automatic t_refuse();
    logic got;
    send(8'h01, `PCH_OP_SET_AXIS, 8'h04, 8'h00, 32'h0000_0099, 8'h01, got);
    chk({31'h0, got}, 32'h0, "bad checksum silent");
    send(8'h02, `PCH_OP_SET_AXIS, 8'h04, 8'h00, 32'h0000_0099, 8'h00, got);
    chk({31'h0, got}, 32'h0, "other address silent");
    cmd(`PCH_OP_GET_AXIS, 8'h04, 8'h00, 32'h0, `PCH_ST_OK);
    chk(rv, 32'h0000_03e8, "dropped frames had no effect");
    cmd(8'h0c, 8'h00, 8'h00, 32'h0, `PCH_ST_BAD_CMD);
    cmd(`PCH_OP_SET_GLOBAL, 8'h00, 8'h01, 32'h0, `PCH_ST_BAD_VALUE);
  endtask
  // ==========================================================
  // Verdict
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    rx_valid_i = 1'b0;
    rx_byte_i = 8'h00;
    module_addr_i = 8'h01;
    standalone_i = 1'b0;
    stall = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    t_boot();
    t_axis();
    t_global();
    t_refuse();
    report_and_stop();
  end
endmodule
